/* File: hdl/ttc_pkg.sv */
// constants and types shared by the thermal throttle controller
// How it works
// - activation temperature readable in target register
// - hardware steps first, adds gating at minimum point
// - monitor trip temperature fixed, never software visible
// - snoops and interrupts unaffected while throttling
// - thermal gating duty is factory constant
// - frequency drops first, within about 2 us
// - then voltage code steps down one entry at a time to the minimum point's code
// - execution continues during voltage stepping
// - return after cool plus hysteresis, via points
// - stepping up raises voltage before frequency
// - thermal gating runs 37.5 percent, stops 62.5
// - gating period 32 us, frequency independent
// - cool and timer expired ends throttle, gating
// - thermal gating only at minimum operating point
// - software may request gating at programmable duty
// - software enable bit 4 gates immediately
// - duty bits 3:1 select 12.5 to 100 percent running
// - thermal duty overrides software duty when active
package ttc_pkg;
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned RATIO_NS       = 2_000;
   localparam int unsigned RATIO_CYC      = RATIO_NS / (1_000_000_000 / CLK_HZ);
   localparam int unsigned PERIOD_US      = 32;
   localparam int unsigned PERIOD_CYC     = PERIOD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned EIGHTH_CYC     = PERIOD_CYC / 8;
   localparam int unsigned HYST_US        = 1_000;
   localparam int unsigned HYST_CYC       = HYST_US * (CLK_HZ / 1_000_000);
   localparam int unsigned VSTEP_NS       = 1_000;
   localparam int unsigned VSTEP_CYC      = VSTEP_NS / (1_000_000_000 / CLK_HZ);
   // code d runs d+1 eighths: code 2 gives 3/8 running
   localparam logic [2:0]  THERM_DUTY     = 3'h2;
   localparam logic [7:0]  ACT_TEMP_DEF   = 8'h5A;
   localparam logic [3:0]  ADDR_TEMP_TGT  = 4'h0;
   localparam logic [3:0]  ADDR_GATE_CTL  = 4'h1;
   localparam logic [3:0]  ADDR_STATUS    = 4'h2;
   localparam logic [3:0]  ADDR_OP_POINT  = 4'h3;
   localparam int unsigned TGT_TEMP_LSB   = 16;
   localparam int unsigned GATE_EN_BIT    = 4;
   localparam int unsigned DUTY_LSB       = 1;
   localparam int unsigned DUTY_MSB       = 3;
   localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
   typedef enum logic [2:0] {
      TTC_IDLE, TTC_RATIO_DN, TTC_VID_DN, TTC_HOLD, TTC_VID_UP, TTC_RATIO_UP
   } ttc_state_type;
endpackage

/* File: hdl/ttc_gate_if.sv */
// carrier between controller and clock gate generator
`timescale 1ns/1ps
interface ttc_gate_if;
   logic       enable;
   logic [2:0] duty;
   logic       run;
   logic       period_start;
   modport ctl (output enable, output duty, input run, input period_start);
   modport gen (input enable, input duty, output run, output period_start);
endinterface

/* File: hdl/ttc_gate_gen.sv */
// clock gating pattern generator on a fixed period
`timescale 1ns/1ps
module ttc_gate_gen #(
   parameter int unsigned EIGHTH = ttc_pkg::EIGHTH_CYC
) (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   ttc_gate_if.gen   g
);
   if (EIGHTH < 1 || EIGHTH > 65536) begin : g_bad_eighth
      $error("eighth period out of range");
   end
   typedef struct packed {
      logic [15:0] cnt;
      logic [2:0]  slot;
      logic        run;
      logic        start;
   } ttc_gen_type;
   ttc_gen_type s_reg;
   ttc_gen_type s_next;
   always_comb begin
      s_next = s_reg;
      s_next.start = 1'b0;
      if (!g.enable) begin
         s_next.cnt  = 16'h0000;
         s_next.slot = 3'h0;
         s_next.run  = 1'b1;
      end else begin
         // timed on the fixed clock, not the core ratio
         if (s_reg.cnt == 16'(EIGHTH - 1)) begin
            s_next.cnt  = 16'h0000;
            s_next.slot = s_reg.slot + 3'h1;
            if (s_reg.slot == 3'h7) begin
               s_next.start = 1'b1;
            end
         end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
         end
         // duty code d runs d+1 eighths of the period
         s_next.run = (s_next.slot <= g.duty);
      end
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_reg <= '{cnt: 16'h0000, slot: 3'h0, run: 1'b1, start: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end
   assign g.run          = s_reg.run;
   assign g.period_start = s_reg.start;
endmodule // ttc_gate_gen

/* File: hdl/ttc_top.sv */
// thermal throttle controller with avalon register slave
`timescale 1ns/1ps
module ttc_top #(
   parameter int unsigned NPOINTS   = 4,
   parameter int unsigned HYST      = ttc_pkg::HYST_CYC,
   parameter int unsigned RATIO_T   = ttc_pkg::RATIO_CYC,
   parameter int unsigned VSTEP_T   = ttc_pkg::VSTEP_CYC,
   parameter int unsigned EIGHTH    = ttc_pkg::EIGHTH_CYC,
   parameter logic [7:0]  VID_NORM  = 8'h40,
   parameter logic [7:0]  VID_MIN   = 8'h30,
   parameter int unsigned VID_PER_PT = 4
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        over_temp_i,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [2:0]  op_point_o,
   output logic      [7:0]  voltage_id_code_o,
   output logic             core_clk_run_o,
   output logic             thermal_alarm_n_o,
   output logic             tcc_active_o
);
   if (NPOINTS < 2 || NPOINTS > 8) begin : g_bad_points
      $error("NPOINTS out of range");
   end
   if (VID_PER_PT < 1) begin : g_bad_step
      $error("VID_PER_PT too small");
   end
   if (HYST < 1 || RATIO_T < 1 || VSTEP_T < 1) begin : g_bad_timing
      $error("bad timing");
   end

   localparam logic [2:0] PT_MIN = 3'(NPOINTS - 1);

   typedef struct packed {
      ttc_pkg::ttc_state_type st;
      logic [2:0]             pt;
      logic [7:0]             voltage_id_code;
      logic [31:0]            tmr;
      logic [31:0]            hyst;
      logic                   thermal_control_circuit;
      logic                   sw_en;
      logic [2:0]             sw_duty;
      logic                   ack;
      logic [31:0]            rdata;
      logic [15:0]            periods;
   } ttc_top_type;

   ttc_top_type s_reg;
   ttc_top_type s_next;
   ttc_gate_if  gif ();

   ttc_gate_gen #(.EIGHTH(EIGHTH)) u_gen (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .g        (gif.gen)
   );

   // voltage code that belongs to an operating point
   function automatic logic [7:0] vid_of(input logic [2:0] p);
      logic [7:0] v;
      v = VID_NORM - 8'(p * VID_PER_PT);
      if (v < VID_MIN) v = VID_MIN;
      return v;
   endfunction

   logic req;
   logic at_min;
   logic therm_gate;
   assign req        = avs_read | avs_write;
   assign at_min     = (s_reg.pt == PT_MIN) && (s_reg.voltage_id_code == vid_of(PT_MIN));
   // hardware adds gating only once stepping is exhausted
   assign therm_gate = s_reg.thermal_control_circuit && at_min && (s_reg.st == ttc_pkg::TTC_HOLD);

   // thermal duty overrides software duty
   assign gif.enable = therm_gate | s_reg.sw_en;
   assign gif.duty   = therm_gate ? ttc_pkg::THERM_DUTY : s_reg.sw_duty;

   always_comb begin
      s_next = s_reg;
      s_next.ack = 1'b0;
      if (gif.period_start) begin
         s_next.periods = s_reg.periods + 16'h0001;
      end
      // throttle sequencer
      unique case (s_reg.st)
         ttc_pkg::TTC_IDLE: begin
            // trip point is the fixed input, no register
            if (over_temp_i) begin
               s_next.thermal_control_circuit = 1'b1;
               s_next.st  = ttc_pkg::TTC_RATIO_DN;
               s_next.tmr = 32'(RATIO_T);
            end
         end
         ttc_pkg::TTC_RATIO_DN: begin
            // ratio switch first, settles in the 2 us window
            if (s_reg.tmr <= 32'h1) begin
               s_next.pt  = PT_MIN;
               s_next.st  = ttc_pkg::TTC_VID_DN;
               s_next.tmr = 32'(VSTEP_T);
            end else begin
               s_next.tmr = s_reg.tmr - 32'h1;
            end
         end
         ttc_pkg::TTC_VID_DN: begin
            // one table entry per step, core keeps running
            if (s_reg.voltage_id_code <= vid_of(s_reg.pt)) begin
               s_next.st   = ttc_pkg::TTC_HOLD;
               s_next.hyst = 32'(HYST);
            end else if (s_reg.tmr <= 32'h1) begin
               s_next.voltage_id_code = s_reg.voltage_id_code - 8'h01;
               s_next.tmr = 32'(VSTEP_T);
            end else begin
               s_next.tmr = s_reg.tmr - 32'h1;
            end
         end
         ttc_pkg::TTC_HOLD: begin
            // leave only when cool and hysteresis expired
            if (over_temp_i) begin
               s_next.hyst = 32'(HYST);
            end else if (s_reg.hyst <= 32'h1) begin
               s_next.st  = ttc_pkg::TTC_VID_UP;
               s_next.tmr = 32'(VSTEP_T);
               s_next.thermal_control_circuit = 1'b0;
            end else begin
               s_next.hyst = s_reg.hyst - 32'h1;
            end
         end
         ttc_pkg::TTC_VID_UP: begin
            // voltage rises to next point before frequency
            if (over_temp_i) begin
               s_next.thermal_control_circuit = 1'b1;
               s_next.st  = ttc_pkg::TTC_RATIO_DN;
               s_next.tmr = 32'(RATIO_T);
            end else if (s_reg.voltage_id_code >= vid_of(s_reg.pt - 3'h1)) begin
               s_next.st  = ttc_pkg::TTC_RATIO_UP;
               s_next.tmr = 32'(RATIO_T);
            end else if (s_reg.tmr <= 32'h1) begin
               s_next.voltage_id_code = s_reg.voltage_id_code + 8'h01;
               s_next.tmr = 32'(VSTEP_T);
            end else begin
               s_next.tmr = s_reg.tmr - 32'h1;
            end
         end
         ttc_pkg::TTC_RATIO_UP: begin
            // through intermediate points back to normal
            if (over_temp_i) begin
               // hot again on the way up: throttle afresh
               s_next.thermal_control_circuit = 1'b1;
               s_next.st  = ttc_pkg::TTC_RATIO_DN;
               s_next.tmr = 32'(RATIO_T);
            end else if (s_reg.tmr <= 32'h1) begin
               s_next.pt  = s_reg.pt - 3'h1;
               s_next.tmr = 32'(VSTEP_T);
               s_next.st  = (s_reg.pt == 3'h1) ? ttc_pkg::TTC_IDLE
                                                : ttc_pkg::TTC_VID_UP;
            end else begin
               s_next.tmr = s_reg.tmr - 32'h1;
            end
         end
         default: s_next.st = ttc_pkg::TTC_IDLE;
      endcase
      // avalon slave: one wait cycle, then answer
      if (req && !s_reg.ack) begin
         s_next.ack   = 1'b1;
         s_next.rdata = ttc_pkg::UNMAPPED_DATA;
         if (avs_read) begin
            unique case (avs_address)
               ttc_pkg::ADDR_TEMP_TGT:
                  // activation temperature readable
                  s_next.rdata[ttc_pkg::TGT_TEMP_LSB +: 8] =
                     ttc_pkg::ACT_TEMP_DEF;
               ttc_pkg::ADDR_GATE_CTL: begin
                  s_next.rdata[ttc_pkg::GATE_EN_BIT] = s_reg.sw_en;
                  s_next.rdata[ttc_pkg::DUTY_MSB:ttc_pkg::DUTY_LSB] =
                     s_reg.sw_duty;
               end
               ttc_pkg::ADDR_STATUS:
                  s_next.rdata = {s_reg.periods, 8'h00, 1'b0,
                                  ttc_pkg::ttc_state_type'(s_reg.st),
                                  gif.run, therm_gate, at_min,
                                  s_reg.thermal_control_circuit};
               ttc_pkg::ADDR_OP_POINT:
                  s_next.rdata = {21'h000000, s_reg.pt, s_reg.voltage_id_code};
               default: s_next.rdata = ttc_pkg::UNMAPPED_DATA;
            endcase
         end
      end else if (avs_write && s_reg.ack &&
                   avs_address == ttc_pkg::ADDR_GATE_CTL &&
                   avs_byteenable[0]) begin
         // write lands at the edge that sees waitrequest low
         // software gating starts at once, any temperature
         s_next.sw_en   = avs_writedata[ttc_pkg::GATE_EN_BIT];
         s_next.sw_duty = avs_writedata[ttc_pkg::DUTY_MSB:
                                        ttc_pkg::DUTY_LSB];
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_reg <= '{st: ttc_pkg::TTC_IDLE, pt: 3'h0, voltage_id_code: VID_NORM,
                    tmr: 32'h0, hyst: 32'h0, thermal_control_circuit: 1'b0, sw_en: 1'b0,
                    sw_duty: 3'h0, ack: 1'b0, rdata: 32'h0,
                    periods: 16'h0000};
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_waitrequest   = req & ~s_reg.ack;
   assign avs_readdata      = s_reg.rdata;
   assign op_point_o        = s_reg.pt;
   assign voltage_id_code_o = s_reg.voltage_id_code;
   // gating touches only core clocks, snoop and interrupt paths run
   assign core_clk_run_o    = gif.run;
   assign thermal_alarm_n_o = ~s_reg.thermal_control_circuit;
   assign tcc_active_o      = s_reg.thermal_control_circuit;
endmodule // ttc_top

/* File: verif/ttc_vr_model.sv */
// voltage regulator model that follows single voltage code steps
`timescale 1ns/1ps
module ttc_vr_model #(
   parameter logic [7:0] LEVEL_INIT = 8'h40
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic [7:0] vid_i,
   output logic            step_err_o
);
   logic [7:0] level_reg;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         level_reg  <= LEVEL_INIT;
         step_err_o <= 1'b0;
      end else begin
         if (vid_i != level_reg && vid_i + 8'h01 != level_reg
             && vid_i != level_reg + 8'h01) begin
            step_err_o <= 1'b1;
         end
         level_reg <= vid_i;
      end
   end
endmodule // ttc_vr_model

/* File: verif/ttc_assertions.sv */
// port assertions for the thermal throttle controller
`timescale 1ns/1ps
module ttc_assertions #(
   parameter int unsigned RATIO_T = 10,
   parameter int unsigned NPOINTS = 4
) (
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        over_temp_i,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [2:0]  op_point_o,
   input wire logic [7:0]  voltage_id_code_o,
   input wire logic        core_clk_run_o,
   input wire logic        thermal_alarm_n_o,
   input wire logic        tcc_active_o
);
   localparam int         RT_LO  = RATIO_T - 1;
   localparam int         RT_HI  = RATIO_T + 1;
   localparam logic [2:0] MIN_PT = 3'(NPOINTS - 1);
   logic sw_en_reg;
   // software gating enable as written over the bus
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sw_en_reg <= 1'b0;
      end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                   && avs_address == ttc_pkg::ADDR_GATE_CTL) begin
         sw_en_reg <= avs_writedata[ttc_pkg::GATE_EN_BIT];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_trip;
      !tcc_active_o && over_temp_i;
   endsequence
   sequence s_engage;
      tcc_active_o && !thermal_alarm_n_o;
   endsequence
   sequence s_freq_down;
      ##[RT_LO:RT_HI] (op_point_o == MIN_PT);
   endsequence
   AST_TRIP: assert property (s_trip |=> s_engage)
      else $error("throttle did not engage on over temperature");
   AST_ALARM: assert property (thermal_alarm_n_o == !tcc_active_o)
      else $error("alarm does not mirror throttle state");
   AST_RATIO: assert property ($rose(tcc_active_o) |-> s_freq_down)
      else $error("frequency point not at minimum in time");
   AST_FREQ_FIRST: assert property (
      voltage_id_code_o < $past(voltage_id_code_o) |-> op_point_o != 3'h0)
      else $error("voltage lowered before frequency");
   AST_VID_STEP: assert property ($changed(voltage_id_code_o) |->
      voltage_id_code_o + 8'h01 == $past(voltage_id_code_o)
      || voltage_id_code_o == $past(voltage_id_code_o) + 8'h01)
      else $error("voltage code moved more than one entry");
   AST_GATE_MIN: assert property (!core_clk_run_o && !sw_en_reg
      && !$past(sw_en_reg) |-> $past(tcc_active_o)
      && $past(op_point_o) == MIN_PT)
      else $error("thermal gating away from minimum point");
   AST_RUN_IDLE: assert property (!tcc_active_o && !$past(tcc_active_o)
      && !sw_en_reg && !$past(sw_en_reg) |-> core_clk_run_o)
      else $error("core clock gated with no cause");
   AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer later than one cycle");
   AST_TEMP_RD: assert property (avs_read && !avs_waitrequest
      && avs_address == ttc_pkg::ADDR_TEMP_TGT
      |-> avs_readdata[23:16] == ttc_pkg::ACT_TEMP_DEF)
      else $error("activation temperature field wrong");
endmodule // ttc_assertions
bind ttc_top ttc_assertions #(.RATIO_T(RATIO_T), .NPOINTS(NPOINTS)) u_ast (
   .clk_i(clk_i), .resetn_i(resetn_i), .over_temp_i(over_temp_i),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .op_point_o(op_point_o), .voltage_id_code_o(voltage_id_code_o),
   .core_clk_run_o(core_clk_run_o), .thermal_alarm_n_o(thermal_alarm_n_o),
   .tcc_active_o(tcc_active_o));

/* File: verif/tb_top.sv */
// self-checking bench for the thermal throttle controller
`timescale 1ns/1ps
module tb_top;
   localparam int unsigned EI  = 10;
   localparam int unsigned PER = 8 * EI;
   localparam int unsigned HY  = 50;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        over_temp_i = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, run, alarm_n, thermal_control_circuit, step_err, vid_up = 1'b0;
   logic [2:0]  op, op_prev = 3'h0;
   logic [7:0]  voltage_id_code, vid_prev = 8'h40;
   logic [31:0] seed = 32'h0000E884;
   int          errors = 0;
   int          n_checks = 0;
   int          cnt;
   always #4 clk_i = ~clk_i;
   ttc_top #(.HYST(HY), .RATIO_T(10), .VSTEP_T(5), .EIGHTH(EI)) dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .over_temp_i(over_temp_i),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .op_point_o(op), .voltage_id_code_o(voltage_id_code), .core_clk_run_o(run),
      .thermal_alarm_n_o(alarm_n), .tcc_active_o(thermal_control_circuit));
   ttc_vr_model vr (.clk_i(clk_i), .resetn_i(resetn_i), .vid_i(voltage_id_code),
      .step_err_o(step_err));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_i);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge clk_i);
         k++;
      end
      rd = avs_readdata;
      if (k >= 50) errors++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_i);
   endtask
   // settle for some periods, then count run cycles over one period
   task measure(input int pre);
      repeat (pre * PER) @(posedge clk_i);
      cnt = 0;
      repeat (PER) begin
         @(posedge clk_i);
         cnt += int'(run);
      end
   endtask
   task settle;
      int k;
      k = 0;
      while ((op !== 3'h0 || thermal_control_circuit !== 1'b0) && k < 5000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 5000) errors++;
   endtask
   // each step back up must raise the voltage code first
   always @(posedge clk_i) begin
      if (resetn_i && op < op_prev)
         check("vid before freq", {31'h0, vid_up}, 32'h1);
      if (op != op_prev) vid_up <= 1'b0;
      else if (voltage_id_code > vid_prev) vid_up <= 1'b1;
      op_prev <= op;
      vid_prev <= voltage_id_code;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      seed = xs(seed);
      bus(1'b1, ttc_pkg::ADDR_TEMP_TGT, seed);
      bus(1'b0, ttc_pkg::ADDR_TEMP_TGT, 32'h0);
      check("temp", rd & 32'h00FF0000, {8'h0, ttc_pkg::ACT_TEMP_DEF, 16'h0});
      bus(1'b0, 4'h4 + seed[3:0] % 4'hC, 32'h0);
      check("unmapped", rd, ttc_pkg::UNMAPPED_DATA);
      for (int d = 0; d < 7; d++) begin
         seed = xs(seed);
         bus(1'b1, ttc_pkg::ADDR_GATE_CTL, {seed[31:5], 1'b1, 3'(d), seed[0]});
         measure(1);
         check("sw duty", 32'(cnt), 32'((d + 1) * EI));
      end
      bus(1'b1, ttc_pkg::ADDR_GATE_CTL, 32'h0);
      measure(1);
      check("sw off", 32'(cnt), 32'(PER));
      over_temp_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("alarm", {30'h0, thermal_control_circuit, alarm_n}, 32'h2);
      measure(3);
      check("thermal duty", 32'(cnt), 32'(3 * EI));
      bus(1'b0, ttc_pkg::ADDR_OP_POINT, 32'h0);
      check("op point", rd, {21'h0, 3'h3, 8'h34});
      bus(1'b0, ttc_pkg::ADDR_STATUS, 32'h0);
      check("status", rd & 32'h7, 32'h7);
      bus(1'b1, ttc_pkg::ADDR_GATE_CTL, 32'h0000001D);
      measure(1);
      check("duty override", 32'(cnt), 32'(3 * EI));
      bus(1'b1, ttc_pkg::ADDR_GATE_CTL, 32'h0);
      over_temp_i <= 1'b0;
      repeat (HY - 10) @(posedge clk_i);
      check("hysteresis", {31'h0, thermal_control_circuit}, 32'h1);
      settle;
      check("normal", {19'h0, op, voltage_id_code, run, alarm_n},
            {19'h0, 3'h0, 8'h40, 2'h3});
      repeat (2000) begin
         @(posedge clk_i);
         seed = xs(seed);
         over_temp_i <= (seed[5:0] == 6'h00);
      end
      over_temp_i <= 1'b0;
      settle;
      check("vr steps", {31'h0, step_err}, 32'h0);
      tally_and_finish;
   end
endmodule // tb_top
